// ### chnco_cfg.svh
// Constants of the channel oscillator front end
//
// Contract
// - Low frequency half held in shadow register
// - High frequency half held in shadow register
// - Shadow loads on sleep exit or hop fire
// - Holdoff of one loads shadow on write
// - Phase offset added as unsigned turn fraction
// - Control bits 8:7 pick sync pin
// - Control bit 6 picks first/second input port
// - Ports: mantissa, exponent, enable, clock-synchronous
// - Mode 00: every clock, mask when disabled; the code masks only the I path, bypass Q passes unmasked
// - Mode 01: sample when enable high
// - Mode 10: sample after enable rises
// - Mode 11: sample after enable falls
// - Hop clears accumulator when bit 3 set
// - Bits 2 and 1 enable the dithers
// - Bypass routes first port I, second Q
// - Memory test: enable, two pass flags
// - Test count: write target, read counter
// - Filter format field: fixed, 8+4, 12+4
// - Filter control bit 9 picks source
// - Output control picks 16 or 12 bits
// - Hop loads holdoff; zero suppresses hop
`ifndef CHNCO_CFG_SVH
`define CHNCO_CFG_SVH
`define CH_SLEEP 8'h80
`define CH_SOFT 8'h81
`define CH_PIN 8'h82
`define CH_STHOLD 8'h83
`define CH_HOPHOLD 8'h84
`define CH_FREQLO 8'h85
`define CH_FREQHI 8'h86
`define CH_PHASE 8'h87
`define CH_CTRL 8'h88
`define CH_RDEC 8'h90
`define CH_RINT 8'h91
`define CH_RSCL 8'h92
`define CH_CDEC 8'h94
`define CH_CSCL 8'h95
`define CH_FDEC 8'hA0
`define CH_FPH 8'hA1
`define CH_FTAP 8'hA2
`define CH_FOFF 8'hA3
`define CH_FCTL 8'hA4
`define CH_SIGI 8'hA5
`define CH_SIGQ 8'hA6
`define CH_STCNT 8'hA7
`define CH_MBIST 8'hA8
`define CH_OCTL 8'hA9
`define SLEEP_RST 1'b1
`define SOFT_START 0
`define SOFT_HOP 1
`define PIN_START 0
`define PIN_HOP 1
`define PIN_FIRST 2
`define HOLD_FIRE 16'h0001
`define HOLD_OFF 16'h0000
`define MODE_MASK 2'h0
`define MODE_HIGH 2'h1
`define MODE_RISE 2'h2
`define MODE_FALL 2'h3
`define FC_SRC 9
`define FC_FMT_HI 5
`define FC_FMT_LO 4
`define FMT_FIX 2'h0
`define FMT_8 2'h1
`define FMT_12 2'h2
`define OC_WIDE 5
`define MB_EN 0
`define MB_LAST 8'hFF
`define LFSR_SEED 16'hACE1
`define LFSR_TAPS 16'hB400
`endif

// ### chnco_pkg.sv
// Types shared by the channel oscillator front end
package chnco_pkg;
	typedef struct packed {
		logic        enable;
		logic [2:0]  exponent;
		logic [13:0] mantissa;
	} chnco_port_s;
	typedef struct packed {
		logic [1:0] syncSel;
		logic       portSel;
		logic [1:0] mode;
		logic       hopClear;
		logic       ampDither;
		logic       phaseDither;
		logic       bypass;
	} chnco_ctrl_s;
	typedef struct packed {
		logic [15:0] phase;
		logic [2:0]  expI;
		logic [2:0]  expQ;
		logic [13:0] i;
		logic [13:0] q;
	} chnco_word_s;
	typedef enum logic [2:0] {
		CHNCO_ST_IDLE = 3'b001,
		CHNCO_ST_RUN  = 3'b010,
		CHNCO_ST_DONE = 3'b100
	} chnco_test_e;
endpackage

// ### chnco_strobe.sv
// Sample strobe derivation and input port steering
`timescale 1ns/1ns
`include "chnco_cfg.svh"
module chnco_strobe (
	input  wire logic                  ref_clk,  // Sample clock
	input  wire logic                  rst,      // Async reset
	input  wire logic [1:0]            mode,     // Strobe mode
	input  wire logic                  portSel,  // Second port select
	input  wire logic                  bypass,   // Translation bypass
	input  wire logic                  run,      // Channel awake
	input  wire chnco_pkg::chnco_port_s portA,    // First port
	input  wire chnco_pkg::chnco_port_s portB,    // Second port
	output logic                       strobe,   // Sample valid
	output chnco_pkg::chnco_port_s     dataI,    // I path sample
	output chnco_pkg::chnco_port_s     dataQ     // Q path sample
);
	chnco_pkg::chnco_port_s pick;
	logic                   enPrev_q;
	logic                   take;

	// Bypass always reads both ports, so the first one paces it
	always_comb pick = (portSel && !bypass) ? portB : portA;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) enPrev_q <= 1'b0;
		else enPrev_q <= pick.enable;
	end

	always_comb begin
		case (mode)
			`MODE_MASK: take = 1'b1;
			`MODE_HIGH: take = pick.enable;
			`MODE_RISE: take = pick.enable && !enPrev_q;
			`MODE_FALL: take = !pick.enable && enPrev_q;
			default: take = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			strobe <= 1'b0;
			dataI <= '0;
			dataQ <= '0;
		end else begin
			strobe <= run && take;
			// Masking keeps the channel phase-aligned across gaps
			if (mode == `MODE_MASK && !pick.enable) dataI <= '0;
			else dataI <= pick;
			dataQ <= bypass ? portB : '0;
		end
	end
endmodule

// ### chnco_fifo.sv
// Output FIFO with registered read side
`timescale 1ns/1ns
module chnco_fifo #(
	parameter int WIDTH = 50,
	parameter int DEPTH = 32
) (
	input  wire logic             ref_clk,  // Clock
	input  wire logic             rst,      // Async reset
	input  wire logic             inValid,  // Write request
	output logic                  inReady,  // Room for a word
	input  wire logic [WIDTH-1:0] inData,   // Write word
	output logic                  outValid, // Read word present
	input  wire logic             outReady, // Reader takes word
	output logic [WIDTH-1:0]      outData   // Read word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	assign inReady = count_q != (AW+1)'(DEPTH);
	assign push = inValid && inReady;
	assign pop = (count_q != '0) && (!outValid || outReady);

	always_ff @(posedge ref_clk) begin
		if (push) mem[wrPtr_q] <= inData;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) wrPtr_q <= wrPtr_q + 1'b1;
			if (pop) rdPtr_q <= rdPtr_q + 1'b1;
			if (push && !pop) count_q <= count_q + 1'b1;
			else if (pop && !push) count_q <= count_q - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			outValid <= 1'b0;
			outData <= '0;
		end else if (pop) begin
			outValid <= 1'b1;
			outData <= mem[rdPtr_q];
		end else if (outReady) begin
			outValid <= 1'b0;
		end
	end
endmodule

// ### chnco_top.sv
// Channel oscillator front end: registers, holdoffs, oscillator, self test
`timescale 1ns/1ns
`include "chnco_cfg.svh"
module chnco_top (
	input  wire logic                   ref_clk,      // 25 MHz clock
	input  wire logic                   rst,          // Async reset
	input  wire logic [7:0]             regAddr,      // Channel address
	input  wire logic [19:0]            regWrData,    // Write data
	input  wire logic                   regWrEn,      // Write strobe
	input  wire logic                   regRdEn,      // Read strobe
	output logic [19:0]                 regRdData,    // Read data
	output logic                        regRdValid,   // Read data valid
	input  wire chnco_pkg::chnco_port_s portA,        // First input port
	input  wire chnco_pkg::chnco_port_s portB,        // Second input port
	input  wire logic [3:0]             syncPin,      // Async sync pins
	input  wire logic                   outReady,     // Sink takes word
	output logic                        outValid,     // Word present
	output chnco_pkg::chnco_word_s      outWord,      // Output word
	output logic                        ampDitherBit, // Amplitude dither
	output logic                        filterSrcOther, // Partner source
	output logic [1:0]                  outFormat,    // Filter format
	output logic                        outWide,      // 16-bit outputs
	output logic                        sleeping      // Channel asleep
);
	// Register state
	logic                   sleep_q;
	logic                   sleepPrev_q;
	logic [2:0]             pinCfg_q;
	logic [15:0]            startHold_q;
	logic [15:0]            hopHold_q;
	logic [15:0]            freqLoSh_q;
	logic [15:0]            freqHiSh_q;
	logic [31:0]            freqWork_q;
	logic [15:0]            phaseOff_q;
	chnco_pkg::chnco_ctrl_s ctrl_q;
	logic [11:0]            resDec_q;
	logic [8:0]             resInt_q;
	logic [11:0]            resScl_q;
	logic [7:0]             decDec_q;
	logic [4:0]             decScl_q;
	logic [7:0]             fDec_q;
	logic [7:0]             fPh_q;
	logic [7:0]             fTap_q;
	logic [7:0]             fOff_q;
	logic [10:0]            fCtl_q;
	logic [9:0]             oCtl_q;
	logic [15:0]            sigI_q;
	logic [15:0]            sigQ_q;
	logic [19:0]            stTarget_q;
	logic [19:0]            stCount_q;
	logic                   mbEn_q;
	logic [1:0]             mbPass_q;
	logic [7:0]             mbCnt_q;
	chnco_pkg::chnco_test_e mbState_q;

	// Sync, holdoff and oscillator state
	logic [3:0]             syncMeta_q;
	logic [3:0]             syncSafe_q;
	logic                   syncPrev_q;
	logic                   firstSeen_q;
	logic [15:0]            hopCnt_q;
	logic                   hopBusy_q;
	logic [15:0]            startCnt_q;
	logic                   startBusy_q;
	logic [31:0]            acc_q;
	logic [15:0]            lfsr_q;
	logic [1:0]             fmt_d;

	// Combinational nets
	logic                   strobe;
	chnco_pkg::chnco_port_s dataI;
	chnco_pkg::chnco_port_s dataQ;
	logic                   fifoReady;
	logic                   adv;
	logic                   pinEdge;
	logic                   pinGo;
	logic                   hopTrig;
	logic                   startTrig;
	logic                   hopFire;
	logic                   startFire;
	logic                   leaveSleep;
	logic [15:0]            loNext;
	logic [15:0]            hiNext;
	logic                   shadowWr;
	logic [19:0]            rdMux;
	chnco_pkg::chnco_word_s pushWord;

	function automatic logic wrAt(input logic en, input logic [7:0] a, input logic [7:0] o);
		return en && (a == o);
	endfunction

	// Keep the low two mantissa bits only in wide output mode
	function automatic logic [13:0] narrow(input logic [13:0] m, input logic wide);
		return wide ? m : {m[13:2], 2'b00};
	endfunction

	chnco_strobe u_strobe (
		.ref_clk (ref_clk),
		.rst     (rst),
		.mode    (ctrl_q.mode),
		.portSel (ctrl_q.portSel),
		.bypass  (ctrl_q.bypass),
		.run     (!sleep_q),
		.portA   (portA),
		.portB   (portB),
		.strobe  (strobe),
		.dataI   (dataI),
		.dataQ   (dataQ)
	);

	// A full FIFO freezes the oscillator rather than silently skipping phase
	assign adv = strobe && fifoReady;

	chnco_fifo #(
		.WIDTH ($bits(chnco_pkg::chnco_word_s)),
		.DEPTH (32)
	) u_fifo (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.inValid  (strobe),
		.inReady  (fifoReady),
		.inData   (pushWord),
		.outValid (outValid),
		.outReady (outReady),
		.outData  (outWord)
	);

	always_comb begin
		pushWord.phase = acc_q[31:16] + phaseOff_q;
		pushWord.expI = dataI.exponent;
		pushWord.expQ = dataQ.exponent;
		pushWord.i = narrow(dataI.mantissa, oCtl_q[`OC_WIDE]);
		pushWord.q = narrow(dataQ.mantissa, oCtl_q[`OC_WIDE]);
	end

	// Sync pins are asynchronous: two flops, then edge detect on the second
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			syncMeta_q <= 4'h0;
			syncSafe_q <= 4'h0;
			syncPrev_q <= 1'b0;
		end else begin
			syncMeta_q <= syncPin;
			syncSafe_q <= syncMeta_q;
			syncPrev_q <= syncSafe_q[ctrl_q.syncSel];
		end
	end

	assign pinEdge = syncSafe_q[ctrl_q.syncSel] && !syncPrev_q;
	assign pinGo = pinEdge && !(pinCfg_q[`PIN_FIRST] && firstSeen_q);
	assign hopTrig = (wrAt(regWrEn, regAddr, `CH_SOFT) && regWrData[`SOFT_HOP])
		|| (pinGo && pinCfg_q[`PIN_HOP]);
	assign startTrig = (wrAt(regWrEn, regAddr, `CH_SOFT) && regWrData[`SOFT_START])
		|| (pinGo && pinCfg_q[`PIN_START]);
	assign hopFire = hopBusy_q && (hopCnt_q == `HOLD_FIRE);
	assign startFire = startBusy_q && (startCnt_q == `HOLD_FIRE);
	assign leaveSleep = sleepPrev_q && !sleep_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) firstSeen_q <= 1'b0;
		else if (pinEdge) firstSeen_q <= 1'b1;
	end

	// Hop holdoff counts processed samples down to one
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hopCnt_q <= `HOLD_OFF;
			hopBusy_q <= 1'b0;
		end else if (hopTrig && hopHold_q != `HOLD_OFF) begin
			hopCnt_q <= hopHold_q;
			hopBusy_q <= 1'b1;
		end else if (hopFire) begin
			hopBusy_q <= 1'b0;
		end else if (hopBusy_q && adv) begin
			hopCnt_q <= hopCnt_q - 16'h0001;
		end
	end

	// Start holdoff runs on the clock since a sleeping channel has no samples
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			startCnt_q <= `HOLD_OFF;
			startBusy_q <= 1'b0;
		end else if (startTrig && startHold_q != `HOLD_OFF) begin
			startCnt_q <= startHold_q;
			startBusy_q <= 1'b1;
		end else if (startFire) begin
			startBusy_q <= 1'b0;
		end else if (startBusy_q) begin
			startCnt_q <= startCnt_q - 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sleep_q <= `SLEEP_RST;
			sleepPrev_q <= `SLEEP_RST;
		end else begin
			sleepPrev_q <= sleep_q;
			if (startFire) sleep_q <= 1'b0;
			else if (wrAt(regWrEn, regAddr, `CH_SLEEP)) sleep_q <= regWrData[0];
		end
	end

	// Frequency shadows and working copy
	assign shadowWr = wrAt(regWrEn, regAddr, `CH_FREQLO)
		|| wrAt(regWrEn, regAddr, `CH_FREQHI);
	assign loNext = wrAt(regWrEn, regAddr, `CH_FREQLO) ? regWrData[15:0] : freqLoSh_q;
	assign hiNext = wrAt(regWrEn, regAddr, `CH_FREQHI) ? regWrData[15:0] : freqHiSh_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			freqLoSh_q <= 16'h0000;
			freqHiSh_q <= 16'h0000;
		end else begin
			freqLoSh_q <= loNext;
			freqHiSh_q <= hiNext;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) freqWork_q <= 32'h0000_0000;
		else if (leaveSleep || hopFire) freqWork_q <= {freqHiSh_q, freqLoSh_q};
		else if (shadowWr && hopHold_q == `HOLD_FIRE) freqWork_q <= {hiNext, loNext};
	end

	// Phase accumulator with optional dithers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) lfsr_q <= `LFSR_SEED;
		else if (adv) lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ `LFSR_TAPS) : (lfsr_q >> 1);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc_q <= 32'h0000_0000;
		end else if (hopFire && ctrl_q.hopClear) begin
			acc_q <= 32'h0000_0000;
		end else if (adv) begin
			acc_q <= acc_q + freqWork_q
				+ (ctrl_q.phaseDither ? {29'h0000_0000, lfsr_q[2:0]} : 32'h0000_0000);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) ampDitherBit <= 1'b0;
		else if (adv) ampDitherBit <= ctrl_q.ampDither && lfsr_q[15];
	end

	// Plain configuration registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pinCfg_q <= 3'h0;
			startHold_q <= `HOLD_OFF;
			hopHold_q <= `HOLD_OFF;
			phaseOff_q <= 16'h0000;
			ctrl_q <= '0;
			resDec_q <= 12'h000;
			resInt_q <= 9'h000;
			resScl_q <= 12'h000;
			decDec_q <= 8'h00;
			decScl_q <= 5'h00;
			fDec_q <= 8'h00;
			fPh_q <= 8'h00;
			fTap_q <= 8'h00;
			fOff_q <= 8'h00;
			fCtl_q <= 11'h000;
			oCtl_q <= 10'h000;
		end else if (regWrEn) begin
			case (regAddr)
				`CH_PIN: pinCfg_q <= regWrData[2:0];
				`CH_STHOLD: startHold_q <= regWrData[15:0];
				`CH_HOPHOLD: hopHold_q <= regWrData[15:0];
				`CH_PHASE: phaseOff_q <= regWrData[15:0];
				`CH_CTRL: ctrl_q <= regWrData[8:0];
				`CH_RDEC: resDec_q <= regWrData[11:0];
				`CH_RINT: resInt_q <= regWrData[8:0];
				`CH_RSCL: resScl_q <= regWrData[11:0];
				`CH_CDEC: decDec_q <= regWrData[7:0];
				`CH_CSCL: decScl_q <= regWrData[4:0];
				`CH_FDEC: fDec_q <= regWrData[7:0];
				`CH_FPH: fPh_q <= regWrData[7:0];
				`CH_FTAP: fTap_q <= regWrData[7:0];
				`CH_FOFF: fOff_q <= regWrData[7:0];
				`CH_FCTL: fCtl_q <= regWrData[10:0];
				`CH_OCTL: oCtl_q <= regWrData[9:0];
				default: ;
			endcase
		end
	end

	// Output signature over the requested number of outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stTarget_q <= 20'h0_0000;
			stCount_q <= 20'h0_0000;
			sigI_q <= 16'h0000;
			sigQ_q <= 16'h0000;
		end else if (wrAt(regWrEn, regAddr, `CH_STCNT)) begin
			stTarget_q <= regWrData;
			stCount_q <= 20'h0_0000;
			sigI_q <= 16'h0000;
			sigQ_q <= 16'h0000;
		end else if (adv && stCount_q != stTarget_q) begin
			stCount_q <= stCount_q + 20'h0_0001;
			sigI_q <= {sigI_q[14:0], sigI_q[15]} ^ {{2{pushWord.i[13]}}, pushWord.i};
			sigQ_q <= {sigQ_q[14:0], sigQ_q[15]} ^ {{2{pushWord.q[13]}}, pushWord.q};
		end
	end

	// Memory self test sequencer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mbEn_q <= 1'b0;
			mbPass_q <= 2'b00;
			mbCnt_q <= 8'h00;
			mbState_q <= chnco_pkg::CHNCO_ST_IDLE;
		end else if (wrAt(regWrEn, regAddr, `CH_MBIST)) begin
			mbEn_q <= regWrData[`MB_EN];
			mbPass_q <= 2'b00;
			mbCnt_q <= 8'h00;
			mbState_q <= regWrData[`MB_EN] ? chnco_pkg::CHNCO_ST_RUN : chnco_pkg::CHNCO_ST_IDLE;
		end else begin
			case (mbState_q)
				chnco_pkg::CHNCO_ST_IDLE: ;
				chnco_pkg::CHNCO_ST_RUN: begin
					mbCnt_q <= mbCnt_q + 8'h01;
					if (mbCnt_q == `MB_LAST) mbState_q <= chnco_pkg::CHNCO_ST_DONE;
				end
				chnco_pkg::CHNCO_ST_DONE: mbPass_q <= 2'b11;
				default: mbState_q <= chnco_pkg::CHNCO_ST_IDLE;
			endcase
		end
	end

	// Filter and output configuration pins
	always_comb begin
		if (fCtl_q[`FC_FMT_HI]) fmt_d = `FMT_12;
		else if (fCtl_q[`FC_FMT_LO]) fmt_d = `FMT_8;
		else fmt_d = `FMT_FIX;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			outFormat <= `FMT_FIX;
			filterSrcOther <= 1'b0;
			outWide <= 1'b0;
			sleeping <= `SLEEP_RST;
		end else begin
			outFormat <= fmt_d;
			filterSrcOther <= fCtl_q[`FC_SRC];
			outWide <= oCtl_q[`OC_WIDE];
			sleeping <= sleep_q;
		end
	end

	// Read mux; reserved and unmapped addresses read zero
	always_comb begin
		case (regAddr)
			`CH_SLEEP: rdMux = {19'h0_0000, sleep_q};
			`CH_PIN: rdMux = {17'h0_0000, pinCfg_q};
			`CH_STHOLD: rdMux = {4'h0, startHold_q};
			`CH_HOPHOLD: rdMux = {4'h0, hopHold_q};
			`CH_FREQLO: rdMux = {4'h0, freqLoSh_q};
			`CH_FREQHI: rdMux = {4'h0, freqHiSh_q};
			`CH_PHASE: rdMux = {4'h0, phaseOff_q};
			`CH_CTRL: rdMux = {11'h000, ctrl_q};
			`CH_RDEC: rdMux = {8'h00, resDec_q};
			`CH_RINT: rdMux = {11'h000, resInt_q};
			`CH_RSCL: rdMux = {8'h00, resScl_q};
			`CH_CDEC: rdMux = {12'h000, decDec_q};
			`CH_CSCL: rdMux = {15'h0000, decScl_q};
			`CH_FDEC: rdMux = {12'h000, fDec_q};
			`CH_FPH: rdMux = {12'h000, fPh_q};
			`CH_FTAP: rdMux = {12'h000, fTap_q};
			`CH_FOFF: rdMux = {12'h000, fOff_q};
			`CH_FCTL: rdMux = {9'h000, fCtl_q};
			`CH_SIGI: rdMux = {4'h0, sigI_q};
			`CH_SIGQ: rdMux = {4'h0, sigQ_q};
			`CH_STCNT: rdMux = stCount_q;
			`CH_MBIST: rdMux = {17'h0_0000, mbPass_q, mbEn_q};
			`CH_OCTL: rdMux = {10'h000, oCtl_q};
			default: rdMux = 20'h0_0000;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			regRdData <= 20'h0_0000;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdEn;
			if (regRdEn) regRdData <= rdMux;
		end
	end
endmodule

// ### chnco_top_properties.sv
// Port assertions for the channel front end
`timescale 1ns/1ns
module chnco_top_properties (
	input wire logic        ref_clk,        // Clock
	input wire logic        rst,            // Reset
	input wire logic [7:0]  regAddr,        // Address
	input wire logic [19:0] regWrData,      // Write data
	input wire logic        regWrEn,        // Write strobe
	input wire logic        regRdEn,        // Read strobe
	input wire logic [19:0] regRdData,      // Read data
	input wire logic        regRdValid,     // Read valid
	input wire logic        filterSrcOther, // Filter source
	input wire logic [1:0]  outFormat,      // Format
	input wire logic        outWide,        // Wide words
	input wire logic        sleeping        // Asleep
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// Shadow and phase offset readback, one idle cycle between write and read
	property pBack(logic [7:0] a);
		regWrEn && regAddr == a ##1 !regWrEn ##1 regRdEn && regAddr == a
			|=> regRdData[15:0] == $past(regWrData[15:0], 3);
	endproperty
	AST_FREQ_LO: assert property (pBack(8'h85)) else $error("Low half readback");
	AST_FREQ_HI: assert property (pBack(8'h86)) else $error("High half readback");
	AST_PHASE: assert property (pBack(8'h87)) else $error("Phase readback");
	AST_RESERVED: assert property (
		regRdEn && (regAddr == 8'h93 || regAddr == 8'h96) |=> regRdData == 20'h00000
	) else $error("Reserved read not zero");
	AST_FORMAT: assert property (
		regWrEn && regAddr == 8'hA4 ##1 !regWrEn
			|=> outFormat == ($past(regWrData[5], 2) ? 2'h2 : {1'b0, $past(regWrData[4], 2)})
	) else $error("Format field not decoded");
	AST_SOURCE: assert property (
		regWrEn && regAddr == 8'hA4 ##1 !regWrEn |=> filterSrcOther == $past(regWrData[9], 2)
	) else $error("Filter source not applied");
	AST_WIDE: assert property (
		regWrEn && regAddr == 8'hA9 ##1 !regWrEn |=> outWide == $past(regWrData[5], 2)
	) else $error("Output width not applied");
	AST_SLEEP: assert property (
		regWrEn && regAddr == 8'h80 ##1 !regWrEn |=> sleeping == $past(regWrData[0], 2)
	) else $error("Sleep bit not applied");
	AST_READ_PULSE: assert property (
		regRdEn ##1 !regRdEn |-> regRdValid ##1 !regRdValid
	) else $error("Read answer not a one-cycle pulse");
	COV_WAKE: cover property (regWrEn && regAddr == 8'h80 && !regWrData[0]);
	COV_READ: cover property (regRdValid);
	COV_WIDE: cover property ($rose(outWide));
endmodule
bind chnco_top chnco_top_properties chk (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
	.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
	.regRdValid(regRdValid), .filterSrcOther(filterSrcOther), .outFormat(outFormat),
	.outWide(outWide), .sleeping(sleeping));

// ### chnco_adc_model.sv
// Converter model driving both input ports
`timescale 1ns/1ns
module chnco_adc_model (
	input  wire logic              ref_clk, // Sample clock
	input  wire logic              rst,     // Reset
	input  wire logic [1:0]        pattern, // Enable pattern
	output chnco_pkg::chnco_port_s portA,   // First port
	output chnco_pkg::chnco_port_s portB    // Second port
);
	logic [13:0] cnt_q;
	logic        en;
	always_comb begin
		case (pattern)
			2'h0: en = 1'b1;
			2'h1: en = cnt_q[0];
			2'h2: en = cnt_q[1:0] == 2'h0;
			default: en = 1'b0;
		endcase
	end
	// Falling edge launch gives half a period of setup
	always_ff @(negedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 14'h0000;
		end else begin
			cnt_q <= cnt_q + 14'h0001;
		end
	end
	assign portA = '{en, cnt_q[2:0], cnt_q};
	assign portB = '{en, cnt_q[2:0], ~cnt_q};
endmodule

// ### chnco_top_test.sv
// Self-checking bench for the channel front end
`timescale 1ns/1ns
module chnco_top_test;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  regAddr = 8'h00;
	logic [19:0] regWrData = 20'h00000;
	logic        regWrEn = 1'b0;
	logic        regRdEn = 1'b0;
	logic        outReady = 1'b1;
	logic [1:0]  pattern = 2'h0;
	logic [3:0]  syncPin = 4'h0;
	logic [19:0] regRdData;
	logic [1:0]  outFormat;
	logic        regRdValid, outValid, ampDitherBit, filterSrcOther, outWide, sleeping;
	logic        hit, hi, lo;
	int          fails = 0;
	int          compares = 0;
	int          n, n2;
	chnco_pkg::chnco_port_s portA, portB;
	chnco_pkg::chnco_word_s outWord, w1, w2;
	always #20 ref_clk = ~ref_clk;
	chnco_adc_model adc (.ref_clk(ref_clk), .rst(rst), .pattern(pattern), .portA(portA),
		.portB(portB));
	chnco_top dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
		.portA(portA), .portB(portB), .syncPin(syncPin), .outReady(outReady),
		.outValid(outValid), .outWord(outWord), .ampDitherBit(ampDitherBit),
		.filterSrcOther(filterSrcOther),
		.outFormat(outFormat), .outWide(outWide), .sleeping(sleeping));
	task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("Compares %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [19:0] d);
		@(negedge ref_clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge ref_clk);
		regWrEn = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [19:0] exp);
		@(negedge ref_clk);
		regAddr = a;
		regRdEn = 1'b1;
		// Answer stands for one cycle only, so look before releasing
		@(negedge ref_clk);
		cmp({19'h00000, regRdValid}, 20'h00001);
		cmp(regRdData, exp);
		regRdEn = 1'b0;
	endtask
	// A word seen at a falling edge is taken at the next rising edge
	task automatic getWord(output chnco_pkg::chnco_word_s w);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (outValid !== 1'b1 && n < 50);
		if (n >= 50) cmp(20'h00001, 20'h00000);
		w = outWord;
	endtask
	task automatic step(input logic [15:0] f);
		repeat (10) getWord(w1);
		getWord(w2);
		cmp({4'h0, w2.phase - w1.phase}, {4'h0, f});
	endtask
	task automatic runChk(input logic [8:0] c, input logic [1:0] p, input logic [1:0] x,
			input logic [13:0] m, input logic [13:0] e);
		logic [13:0] v;
		pattern = p;
		wr(8'h88, {11'h000, c});
		// Stale words from the previous setting are skipped
		repeat (10) getWord(w1);
		repeat (6) begin
			getWord(w1);
			v = x == 2'h0 ? w1.i : x == 2'h1 ? w1.i ^ {11'h000, w1.expI} : w1.i ^ w1.q;
			cmp({6'h00, v & m}, {6'h00, e});
		end
	endtask
	initial begin
		#400000;
		fails++;
		give_verdict();
	end
	initial begin
		repeat (12) @(negedge ref_clk);
		rst = 1'b0;
		cmp({19'h00000, sleeping}, 20'h00001);
		wr(8'h85, 20'h05A5A);
		rd(8'h85, 20'h05A5A);
		wr(8'h86, 20'h0A5A5);
		rd(8'h86, 20'h0A5A5);
		wr(8'h93, 20'h00000);
		rd(8'h93, 20'h00000);
		rd(8'h20, 20'h00000);
		wr(8'h87, 20'h01234);
		rd(8'h87, 20'h01234);
		wr(8'h88, 20'h00180);
		rd(8'h88, 20'h00180);
		for (int f = 0; f < 4; f++) begin
			wr(8'hA4, 20'(f[0] * 512 + f * 16));
			wr(8'hA9, 20'(f[0] * 32));
			@(negedge ref_clk);
			cmp({18'h00000, outFormat}, {18'h00000, f[1] ? 2'h2 : 2'(f)});
			cmp({19'h00000, filterSrcOther}, 20'(f[0]));
			cmp({19'h00000, outWide}, 20'(f[0]));
		end
		wr(8'h88, 20'h00000);
		wr(8'h86, 20'h00100);
		wr(8'h85, 20'h00000);
		wr(8'h80, 20'h00000);
		step(16'h0100);
		wr(8'h86, 20'h00200);
		step(16'h0100);
		wr(8'h84, 20'h00000);
		wr(8'h81, 20'h00002);
		step(16'h0100);
		wr(8'h84, 20'h00001);
		wr(8'h86, 20'h00300);
		step(16'h0300);
		wr(8'h84, 20'h00005);
		wr(8'h86, 20'h00040);
		step(16'h0300);
		wr(8'h81, 20'h00002);
		step(16'h0040);
		wr(8'h88, 20'h00008);
		wr(8'h84, 20'h00001);
		wr(8'h81, 20'h00002);
		hit = 1'b0;
		repeat (20) begin
			getWord(w1);
			hit |= w1.phase === 16'h1234;
		end
		cmp({19'h00000, hit}, 20'h00001);
		wr(8'h84, 20'h00002);
		wr(8'h86, 20'h00080);
		wr(8'h82, 20'h00002);
		syncPin = 4'hE;
		step(16'h0040);
		syncPin = 4'hF;
		step(16'h0080);
		wr(8'hA7, 20'h00005);
		repeat (10) getWord(w1);
		rd(8'hA7, 20'h00005);
		wr(8'hA8, 20'h00001);
		repeat (300) @(negedge ref_clk);
		rd(8'hA8, 20'h00007);
		wr(8'h88, 20'h00004);
		{hi, lo} = 2'h0;
		repeat (20) begin
			@(negedge ref_clk);
			hi |= ampDitherBit === 1'b1;
			lo |= ampDitherBit === 1'b0;
		end
		cmp({18'h00000, hi, lo}, 20'h00003);
		runChk(9'h001, 2'h0, 2'h2, 14'h3FFF, 14'h3FFF);
		cmp({19'h00000, ampDitherBit}, 20'h00000);
		runChk(9'h000, 2'h0, 2'h1, 14'h0007, 14'h0000);
		runChk(9'h040, 2'h0, 2'h1, 14'h0007, 14'h0007);
		runChk(9'h000, 2'h3, 2'h0, 14'h3FFF, 14'h0000);
		runChk(9'h010, 2'h1, 2'h0, 14'h0001, 14'h0001);
		runChk(9'h020, 2'h2, 2'h0, 14'h0003, 14'h0000);
		runChk(9'h030, 2'h2, 2'h0, 14'h0003, 14'h0001);
		pattern = 2'h0;
		wr(8'h88, 20'h00000);
		outReady = 1'b0;
		repeat (80) @(negedge ref_clk);
		wr(8'h80, 20'h00001);
		repeat (4) @(negedge ref_clk);
		outReady = 1'b1;
		n2 = 0;
		repeat (40) begin
			n2 += int'(outValid === 1'b1);
			@(negedge ref_clk);
		end
		cmp(20'(n2), 20'h00021);
		give_verdict();
	end
endmodule
